//--- bench/storage_model.sv
// Purpose: Core storage partner answering one character access at a time
// Assumes: mem_req held until mem_ack, one-cycle ack pulse
// Notes: lat sets extra wait cycles before the answer
`timescale 1ns/1ps
`default_nettype none
module storage_model import bcd_pkg::*; (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Request side
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [WADDR_W-1:0] mem_word_addr,
   input wire logic [WORD_W-1:0] mem_wdata,
   input wire logic [3:0] mem_wmask,
   input wire logic [1:0] lat,
   // Answer side
   output logic [WORD_W-1:0] mem_rdata,
   output logic mem_ack
);
   logic [WORD_W-1:0] mem [0:63];
   logic [1:0] wait_q;
   // Data toggles outside the answer so stale reads never look valid
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mem_ack <= 1'b0;
         wait_q <= 2'h0;
         mem_rdata <= 24'h000000;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == lat) begin
               mem_ack <= 1'b1;
               wait_q <= 2'h0;
               mem_rdata <= mem[mem_word_addr[5:0]];
               for (int k = 0; k < 4; k++) begin
                  if (mem_we && mem_wmask[k]) begin
                     mem[mem_word_addr[5:0]][6*k +: 6] <= mem_wdata[6*k +: 6];
                  end
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: Self-checking bench for the decimal field unit
// Assumes: Expected results queued at issue, checked at op_done
// Notes: Field contents written straight into the storage model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bcd_pkg::*;
   typedef struct packed {logic flt; logic [LEN_W-1:0] len; logic [ACC_W-1:0] acc;} exp_s;
   logic sys_clk, reset, op_valid, sense_req, irq_select, op_busy, op_done, sense_valid;
   logic sense_fault, decimal_fault, fault_irq, mem_req, mem_we, mem_ack, flt_m;
   logic [5:0] op_code;
   logic [2:0] op_sub;
   logic [CADDR_W-1:0] op_operand;
   logic [WADDR_W-1:0] mem_word_addr;
   logic [WORD_W-1:0] mem_wdata, mem_rdata;
   logic [3:0] mem_wmask;
   logic [1:0] lat;
   logic [ACC_W-1:0] decimal_accumulator, acc_m, a;
   logic [LEN_W-1:0] field_length, len_m;
   logic [31:0] rnd;
   exp_s oq[$];
   logic sq[$];
   int n_errors, tests_run, done_cnt, cyc, n;

   bcd_decimal_field_unit dut (.sys_clk(sys_clk), .reset(reset), .op_valid(op_valid),
      .op_code(op_code), .op_sub(op_sub), .op_operand(op_operand), .op_busy(op_busy),
      .op_done(op_done), .sense_req(sense_req), .irq_select(irq_select),
      .sense_valid(sense_valid), .sense_fault(sense_fault), .decimal_fault(decimal_fault),
      .fault_irq(fault_irq), .mem_req(mem_req), .mem_we(mem_we),
      .mem_word_addr(mem_word_addr), .mem_wdata(mem_wdata), .mem_wmask(mem_wmask),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .decimal_accumulator(decimal_accumulator),
      .field_length(field_length));
   storage_model u_mem (.sys_clk(sys_clk), .reset(reset), .mem_req(mem_req), .mem_we(mem_we),
      .mem_word_addr(mem_word_addr), .mem_wdata(mem_wdata), .mem_wmask(mem_wmask),
      .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

   // ----------------------------------------------------------------
   // Reference helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [ACC_W-1:0] to_bcd(longint v);
      logic [ACC_W-1:0] r;
      r = '0;
      r[SIGN_BIT] = v < 0;
      if (v < 0) v = -v;
      for (int i = 0; i < ACC_DIGITS; i++) begin
         r[4*i +: 4] = 4'(v % 10);
         v = v / 10;
      end
      return r;
   endfunction
   function automatic longint to_int(logic [ACC_W-1:0] x);
      longint v;
      v = 0;
      for (int i = ACC_DIGITS - 1; i >= 0; i--) v = v * 10 + x[4*i +: 4];
      return x[SIGN_BIT] ? -v : v;
   endfunction
   function automatic logic [ACC_W-1:0] rd_field(int base, int len, inout logic f);
      logic [5:0] c;
      logic [ACC_W-1:0] r;
      r = '0;
      for (int i = 0; i < len; i++) begin
         c = u_mem.mem[(base + i) / 4][23 - 6 * ((base + i) % 4) -: 6];
         if (c[3:0] > DIGIT_MAX) f = 1'b1;
         if (i < len - 1 && c[5:4] != ZONE_CLEAR) f = 1'b1;
         if (i == len - 1) r[SIGN_BIT] = (c[5:4] == SIGN_NEG);
         r[4*(len-1-i) +: 4] = (c[3:0] > DIGIT_MAX) ? DIGIT_ZERO : c[3:0];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Drivers and checks
   // ----------------------------------------------------------------
   task automatic put_char(int ca, logic [5:0] c);
      u_mem.mem[ca / 4][23 - 6 * (ca % 4) -: 6] = c;
   endtask
   task automatic put_field(int base, int len, logic [ACC_W-1:0] x);
      for (int i = 0; i < len; i++)
         put_char(base + len - 1 - i, {(i == 0 && x[SIGN_BIT]) ? SIGN_NEG : ZONE_CLEAR, x[4*i +: 4]});
   endtask
   task automatic cmp_op(exp_s e);
      tests_run++;
      if ({decimal_fault, field_length, decimal_accumulator} !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t: result %h expected %h", $time,
            {decimal_fault, field_length, decimal_accumulator}, e);
      end
   endtask
   task automatic cmp_bit(logic g, logic e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t: flag %b expected %b", $time, g, e);
      end
   endtask
   task automatic issue(logic [5:0] c, logic [2:0] s, int opnd);
      int start;
      start = done_cnt;
      oq.push_back({flt_m, len_m, acc_m});
      op_valid = 1'b1;
      op_code = c;
      op_sub = s;
      op_operand = CADDR_W'(opnd);
      @(negedge sys_clk);
      op_valid = 1'b0;
      cmp_bit(op_busy, c != OP_MISC);
      for (int i = 0; i < 300 && done_cnt == start; i++) @(negedge sys_clk);
   endtask
   task automatic set_len(int v);
      len_m = LEN_W'(v);
      if (v > 12) flt_m = 1'b1;
      issue(OP_MISC, SUB_SET_LEN, v);
   endtask
   task automatic load(int base);
      acc_m = rd_field(base, len_m, flt_m);
      issue(OP_LOAD, 3'h0, base);
   endtask
   task automatic arith(logic [5:0] c, int base);
      longint v;
      v = to_int(rd_field(base, len_m, flt_m));
      acc_m = to_bcd(to_int(acc_m) + ((c == OP_ADD) ? v : -v));
      issue(c, 3'h0, base);
   endtask
   task automatic shift(logic [2:0] s, int k);
      if (s == SUB_SHL) acc_m[MAG_W-1:0] = acc_m[MAG_W-1:0] << (4 * k);
      else acc_m[MAG_W-1:0] = acc_m[MAG_W-1:0] >> (4 * k);
      issue(OP_MISC, s, k);
   endtask
   task automatic sense();
      sq.push_back(flt_m);
      sense_req = 1'b1;
      @(negedge sys_clk);
      sense_req = 1'b0;
      flt_m = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic end_sim();
      if (oq.size() != 0 || sq.size() != 0) n_errors++;
      if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   always @(negedge sys_clk) begin
      if (op_done) begin
         done_cnt++;
         cmp_op(oq.size() ? oq.pop_front() : 'x);
      end
      if (sense_valid) cmp_bit(sense_fault, sq.size() ? sq.pop_front() : 1'bx);
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial begin
      {reset, op_valid, sense_req, irq_select, flt_m} = 5'h10;
      {op_code, op_sub, op_operand, lat} = '0;
      {acc_m, len_m, rnd} = {53'h0, LEN_RESET, 32'h22BF};
      for (int i = 0; i < 64; i++) u_mem.mem[i] = 24'h000000;
      repeat (12) @(negedge sys_clk);
      reset = 1'b0;
      cmp_op({1'b0, LEN_RESET, 53'h0});
      set_len(3);
      put_field(5, 3, to_bcd(-123));
      load(5);
      put_field(12, 3, to_bcd(9));
      lat = 2'h3;
      arith(OP_ADD, 12);
      put_field(16, 3, to_bcd(-200));
      arith(OP_SUB, 16);
      shift(SUB_SHL, 2);
      shift(SUB_SHR, 1);
      issue(OP_STORE, 3'h0, 24);
      load(24);
      load(5);
      issue(OP_STORE, 3'h0, 28);
      load(28);
      set_len(12);
      put_field(100, 12, to_bcd(64'hE8D4A50FFF));
      load(100);
      arith(OP_ADD, 100);
      set_len(13);
      irq_select = 1'b1;
      repeat (2) @(negedge sys_clk);
      cmp_bit(fault_irq, 1'b1);
      sense();
      set_len(4);
      put_field(40, 4, to_bcd(1234));
      put_char(41, 6'h0C);
      load(40);
      put_field(44, 4, to_bcd(5));
      arith(OP_ADD, 44);
      sense();
      put_char(41, 6'h11);
      load(40);
      sense();
      set_len(0);
      load(40);
      for (int t = 0; t < 6; t++) begin
         rnd = lfsr(rnd);
         n = int'(rnd[7:0] % 12) + 1;
         set_len(n);
         a = '0;
         for (int i = 0; i < n; i++) begin
            rnd = lfsr(rnd);
            a[4*i +: 4] = 4'(rnd[15:0] % 10);
         end
         put_field(120, n, a);
         put_char(120 + n - 1, {rnd[17:16], a[3:0]});
         lat = rnd[19:18];
         load(120);
      end
      repeat (4) @(negedge sys_clk);
      end_sim();
   end
endmodule
`default_nettype wire

//--- core/bcd_add13.sv
// Purpose: Thirteen-digit ripple decimal adder and subtractor
// Assumes: Inputs hold legal digits
// Notes: carry out high on subtract means a >= b

`timescale 1ns/1ps
`default_nettype none

module bcd_add13 import bcd_pkg::*; (
   dec_add_if.adder ap
);
   function automatic logic [4:0] digit_add(input logic [3:0] x, input logic [3:0] y,
                                           input logic c);
      logic [4:0] s;
      s = {1'b0, x} + {1'b0, y} + {4'h0, c};
      if (s >= DIGIT_RADIX) begin
         digit_add = {1'b1, 4'(s - DIGIT_RADIX)};
      end else begin
         digit_add = s;
      end
   endfunction

   // Nets, not variables: each digit slice has its own driver
   wire [ACC_DIGITS:0] c;
   wire [MAG_W-1:0] sum_w;
   assign c[0] = ap.sub;

   genvar i;
   for (i = 0; i < ACC_DIGITS; i++) begin : g_dig
      wire [3:0] bd = ap.b[DIGIT_W*i +: DIGIT_W];
      wire [3:0] bsel = ap.sub ? 4'(DIGIT_MAX - bd) : bd;
      wire [4:0] r = digit_add(ap.a[DIGIT_W*i +: DIGIT_W], bsel, c[i]);
      assign sum_w[DIGIT_W*i +: DIGIT_W] = r[3:0];
      assign c[i+1] = r[4];
   end
   assign ap.sum = sum_w;
   assign ap.carry = c[ACC_DIGITS];
endmodule

`default_nettype wire

//--- core/bcd_decimal_field_unit.sv
// Purpose: Decimal field load, store, shift, add and subtract unit
// Assumes: Storage answers on the same clock with mem_ack
// Notes: One character per storage access, least significant first

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Load, store, shift, add, subtract decimal digit fields
// - Storage word holds four six-bit characters
// - Digit value is low four bits, 8421
// - Sign 10 in top bits of last char
// - More significant characters sit at lower addresses
// - Accumulator is 53 bits, thirteen digit positions
// - Four-bit length register, zero to twelve legal
// - Digits above nine are used as zero
// - Only least significant character gives the sign
// - Misplaced sign bits raise decimal fault
// - Illegal digit in load, add, subtract faults
// - Length above twelve faults when set
// - Load fetches from base plus length minus one
// - Load always zeroes the thirteenth digit
// - Code 70 sub 7 sets length
// - Sensing reads fault and clears it
// - Fault may raise selected interrupt
module bcd_decimal_field_unit import bcd_pkg::*; (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Instruction from processor control
   input wire logic op_valid,
   input wire logic [5:0] op_code,
   input wire logic [2:0] op_sub,
   input wire logic [CADDR_W-1:0] op_operand,
   output logic op_busy,
   output logic op_done,
   // Status sense and interrupt
   input wire logic sense_req,
   input wire logic irq_select,
   output logic sense_valid,
   output logic sense_fault,
   output logic decimal_fault,
   output logic fault_irq,
   // Core storage port
   output logic mem_req,
   output logic mem_we,
   output logic [WADDR_W-1:0] mem_word_addr,
   output logic [WORD_W-1:0] mem_wdata,
   output logic [3:0] mem_wmask,
   input wire logic [WORD_W-1:0] mem_rdata,
   input wire logic mem_ack,
   // Visible state
   output logic [ACC_W-1:0] decimal_accumulator,
   output logic [LEN_W-1:0] field_length
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [3:0] lane_mask(input logic [1:0] p);
      lane_mask = LANE_FIRST >> p;
   endfunction

   function automatic logic [CHAR_W-1:0] pick_char(input logic [WORD_W-1:0] w,
                                                   input logic [1:0] p);
      pick_char = w[CHAR_W*int'(2'(~p)) +: CHAR_W];
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   state_e state_q;
   logic [5:0] op_q;
   logic [CADDR_W-1:0] base_q;
   logic [CADDR_W-1:0] caddr_q;
   logic [3:0] idx_q;
   logic [ACC_W-1:0] acc_q;
   logic [OPND_W-1:0] opnd_q;
   logic opnd_neg_q;
   logic [LEN_W-1:0] len_q;
   logic fault_q;
   logic busy_q;
   logic done_q;
   logic sense_valid_q;
   logic sense_fault_q;
   logic irq_q;
   logic mem_req_q;
   logic mem_we_q;
   logic [WADDR_W-1:0] mem_word_addr_q;
   logic [WORD_W-1:0] mem_wdata_q;
   logic [3:0] mem_wmask_q;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire idle = state_q == ST_IDLE;
   wire take = idle && op_valid;
   wire is_misc = op_code == OP_MISC;
   wire is_set = is_misc && op_sub == SUB_SET_LEN;
   wire is_shl = is_misc && op_sub == SUB_SHL;
   wire is_shr = is_misc && op_sub == SUB_SHR;
   wire is_arith_in = op_code == OP_ADD || op_code == OP_SUB;
   wire is_field_in = op_code == OP_LOAD || op_code == OP_STORE || is_arith_in;
   wire op_arith = op_q == OP_ADD || op_q == OP_SUB;
   wire op_load = op_q == OP_LOAD;
   wire op_store = op_q == OP_STORE;
   wire [LEN_W-1:0] new_len = op_operand[LEN_W-1:0];
   wire len_bad = new_len > LEN_MAX;

   // Lengths above twelve are clamped so the field never spills over
   wire [3:0] eff_len = (len_q > LEN_MAX) ? LEN_MAX : len_q;
   wire last = idx_q == eff_len - 4'h1;
   wire [CADDR_W-1:0] field_addr = base_q + {13'h0000, eff_len}
                                   - {13'h0000, idx_q} - CADDR_STEP;
   wire [5:0] shamt = {idx_q[3:0], 2'b00};
   wire [5:0] shift_by = {new_len, 2'b00};

   // ---------------------------------------------------------------
   // Character path
   // ---------------------------------------------------------------
   wire [CHAR_W-1:0] rd_char = pick_char(mem_rdata, caddr_q[1:0]);
   wire [DIGIT_W-1:0] rd_digit;
   wire rd_illegal;
   wire rd_misplaced;
   wire rd_negative;
   wire rd_go = state_q == ST_WAIT && mem_ack && !mem_we_q;

   char_check u_check (
      .ch(rd_char),
      .is_lsc(idx_q == 4'h0),
      .digit(rd_digit),
      .illegal(rd_illegal),
      .misplaced(rd_misplaced),
      .negative(rd_negative)
   );

   wire [DIGIT_W-1:0] st_digit = acc_q[shamt +: DIGIT_W];
   wire [1:0] st_zone = (idx_q == 4'h0 && acc_q[SIGN_BIT]) ? SIGN_NEG : ZONE_CLEAR;
   wire [CHAR_W-1:0] st_char = {st_zone, st_digit};

   // ---------------------------------------------------------------
   // Signed magnitude arithmetic
   // ---------------------------------------------------------------
   dec_add_if ap ();

   bcd_add13 u_add (
      .ap(ap)
   );

   wire eff_neg = opnd_neg_q ^ (op_q == OP_SUB);
   wire same_sign = eff_neg == acc_q[SIGN_BIT];
   wire recomp = state_q == ST_RECOMP;
   assign ap.a = recomp ? '0 : acc_q[MAG_W-1:0];
   assign ap.b = recomp ? acc_q[MAG_W-1:0] : {4'h0, opnd_q};
   assign ap.sub = recomp || !same_sign;
   wire need_recomp = !same_sign && !ap.carry;
   wire res_sign = need_recomp ? eff_neg : acc_q[SIGN_BIT];

   // ---------------------------------------------------------------
   // Fault and sense
   // ---------------------------------------------------------------
   wire fault_set = (rd_go && op_q != OP_STORE && (rd_illegal || rd_misplaced))
                    || (take && is_set && len_bad);
   // Set wins over a sense in the same cycle
   wire fault_d = fault_set || (fault_q && !sense_req);

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         fault_q <= 1'b0;
         irq_q <= 1'b0;
         sense_valid_q <= 1'b0;
         sense_fault_q <= 1'b0;
      end else begin
         fault_q <= fault_d;
         irq_q <= fault_d && irq_select;
         sense_valid_q <= sense_req;
         if (sense_req) begin
            sense_fault_q <= fault_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // Storage port
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mem_req_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_word_addr_q <= '0;
         mem_wdata_q <= '0;
         mem_wmask_q <= 4'h0;
         caddr_q <= '0;
      end else if (state_q == ST_REQ) begin
         mem_req_q <= 1'b1;
         mem_we_q <= op_store;
         mem_word_addr_q <= field_addr[CADDR_W-1:2];
         mem_wdata_q <= {4{st_char}};
         mem_wmask_q <= op_store ? lane_mask(field_addr[1:0]) : 4'h0;
         caddr_q <= field_addr;
      end else if (state_q == ST_WAIT && mem_ack) begin
         mem_req_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_wmask_q <= 4'h0;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer and datapath
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_IDLE;
         op_q <= 6'h00;
         base_q <= '0;
         idx_q <= 4'h0;
         acc_q <= '0;
         opnd_q <= '0;
         opnd_neg_q <= 1'b0;
         len_q <= LEN_RESET;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (op_valid) begin
                  op_q <= op_code;
                  base_q <= op_operand;
                  idx_q <= 4'h0;
                  if (is_set) begin
                     len_q <= new_len;
                     done_q <= 1'b1;
                  end else if (is_shl) begin
                     acc_q[MAG_W-1:0] <= acc_q[MAG_W-1:0] << shift_by;
                     done_q <= 1'b1;
                  end else if (is_shr) begin
                     acc_q[MAG_W-1:0] <= acc_q[MAG_W-1:0] >> shift_by;
                     done_q <= 1'b1;
                  end else if (is_field_in) begin
                     busy_q <= 1'b1;
                     opnd_q <= '0;
                     opnd_neg_q <= 1'b0;
                     if (op_code == OP_LOAD) begin
                        acc_q <= '0;
                     end
                     if (eff_len == 4'h0) begin
                        state_q <= is_arith_in ? ST_ARITH : ST_DONE;
                     end else begin
                        state_q <= ST_REQ;
                     end
                  end
               end
            end
            ST_REQ: begin
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               if (mem_ack) begin
                  if (op_load) begin
                     acc_q[shamt +: DIGIT_W] <= rd_digit;
                     if (idx_q == 4'h0) begin
                        acc_q[SIGN_BIT] <= rd_negative;
                     end
                  end
                  if (op_arith) begin
                     opnd_q[shamt +: DIGIT_W] <= rd_digit;
                     if (idx_q == 4'h0) begin
                        opnd_neg_q <= rd_negative;
                     end
                  end
                  idx_q <= idx_q + 4'h1;
                  if (last) begin
                     state_q <= op_arith ? ST_ARITH : ST_DONE;
                  end else begin
                     state_q <= ST_REQ;
                  end
               end
            end
            ST_ARITH: begin
               acc_q <= {res_sign, ap.sum};
               state_q <= need_recomp ? ST_RECOMP : ST_DONE;
            end
            ST_RECOMP: begin
               // Negative difference is brought back to true magnitude
               acc_q[MAG_W-1:0] <= ap.sum;
               state_q <= ST_DONE;
            end
            ST_DONE: begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign op_busy = busy_q;
   assign op_done = done_q;
   assign sense_valid = sense_valid_q;
   assign sense_fault = sense_fault_q;
   assign decimal_fault = fault_q;
   assign fault_irq = irq_q;
   assign mem_req = mem_req_q;
   assign mem_we = mem_we_q;
   assign mem_word_addr = mem_word_addr_q;
   assign mem_wdata = mem_wdata_q;
   assign mem_wmask = mem_wmask_q;
   assign decimal_accumulator = acc_q;
   assign field_length = len_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   wire all_legal = acc_q[3:0] <= DIGIT_MAX && acc_q[7:4] <= DIGIT_MAX
                    && acc_q[47:44] <= DIGIT_MAX && acc_q[27:24] <= DIGIT_MAX;

   chk_fault_sticky: assert property (fault_q && !sense_req |=> fault_q)
      else $error("decimal fault dropped without a sense");
   chk_sense_clear: assert property (sense_req && !fault_set |=> !fault_q ##0 sense_valid)
      else $error("sense did not clear the fault");
   chk_set_length: assert property (take && is_set |=> len_q == $past(new_len) && op_done)
      else $error("length register not written by set");
   chk_set_overlen: assert property (take && is_set && len_bad |=> fault_q)
      else $error("length above twelve did not fault");
   chk_load_top: assert property (op_done && op_load |-> acc_q[51:48] == DIGIT_ZERO)
      else $error("load left a digit in the overflow position");
   chk_load_legal: assert property (op_done && op_load |-> all_legal)
      else $error("loaded digit above nine");
   chk_first_char: assert property (state_q == ST_WAIT && idx_q == 4'h0 |->
                                    caddr_q == base_q + {13'h0000, eff_len} - CADDR_STEP)
      else $error("first access not at least significant character");
   chk_bad_char: assert property (rd_go && op_q != OP_STORE && (rd_illegal || rd_misplaced)
                                  |=> fault_q [*2])
      else $error("bad character did not raise a lasting fault");
   chk_irq_follow: assert property (fault_q && irq_select && !sense_req |=> fault_irq)
      else $error("selected fault gave no interrupt");
   chk_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_word_addr))
      else $error("storage request dropped before answer");

   cov_load: cover property (take && op_code == OP_LOAD ##[1:60] op_done);
   cov_recomp: cover property (state_q == ST_RECOMP ##2 op_done);
   cov_set_fault: cover property (take && is_set && len_bad);
   cov_store: cover property (mem_req && mem_we && mem_ack);

endmodule

`default_nettype wire

//--- core/bcd_pkg.sv
// Purpose: Shared constants and types for the decimal field unit
// Assumes: 24-bit words of four 6-bit characters, 13-digit accumulator
// Notes: Operation codes are given as octal values in hex form

package bcd_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int CHAR_W = 6;
   localparam int DIGIT_W = 4;
   localparam int WORD_W = 24;
   localparam int ACC_DIGITS = 13;
   localparam int MAG_W = ACC_DIGITS * DIGIT_W;
   localparam int ACC_W = MAG_W + 1;
   localparam int OPND_W = 48;
   localparam int SIGN_BIT = MAG_W;
   localparam int CADDR_W = 17;
   localparam int WADDR_W = 15;
   localparam int LEN_W = 4;

   // ----------------------------------------------------------------
   // Operation codes (octal 64..70)
   // ----------------------------------------------------------------
   localparam logic [5:0] OP_LOAD = 6'h34;
   localparam logic [5:0] OP_STORE = 6'h35;
   localparam logic [5:0] OP_ADD = 6'h36;
   localparam logic [5:0] OP_SUB = 6'h37;
   localparam logic [5:0] OP_MISC = 6'h38;
   localparam logic [2:0] SUB_SHL = 3'h4;
   localparam logic [2:0] SUB_SHR = 3'h5;
   localparam logic [2:0] SUB_SET_LEN = 3'h7;

   // ----------------------------------------------------------------
   // Character and digit codes
   // ----------------------------------------------------------------
   localparam logic [1:0] SIGN_NEG = 2'h2;
   localparam logic [1:0] ZONE_CLEAR = 2'h0;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [3:0] DIGIT_ZERO = 4'h0;
   localparam logic [4:0] DIGIT_RADIX = 5'h0A;
   localparam logic [3:0] LEN_MAX = 4'hC;
   localparam logic [3:0] LEN_RESET = 4'h1;
   localparam logic [3:0] LANE_FIRST = 4'h8;
   localparam logic [CADDR_W-1:0] CADDR_STEP = 17'h00001;

   typedef enum {ST_IDLE, ST_REQ, ST_WAIT, ST_ARITH, ST_RECOMP, ST_DONE} state_e;

endpackage

//--- core/char_check.sv
// Purpose: Splits one stored character into digit, sign and legality
// Assumes: Upper two bits are the zone, low four the digit
// Notes: Illegal digits read as zero

`timescale 1ns/1ps
`default_nettype none

module char_check import bcd_pkg::*; (
   // Character in
   input wire logic [CHAR_W-1:0] ch,
   input wire logic is_lsc,
   // Decoded
   output logic [DIGIT_W-1:0] digit,
   output logic illegal,
   output logic misplaced,
   output logic negative
);
   wire [DIGIT_W-1:0] raw = ch[DIGIT_W-1:0];
   wire [1:0] zone = ch[CHAR_W-1:DIGIT_W];

   assign illegal = raw > DIGIT_MAX;
   assign digit = illegal ? DIGIT_ZERO : raw;
   assign misplaced = !is_lsc && zone != ZONE_CLEAR;
   assign negative = is_lsc && zone == SIGN_NEG;
endmodule

`default_nettype wire

//--- core/dec_add_if.sv
// Purpose: Operand and result bundle of the decimal adder
// Assumes: Purely combinational path, one clock
// Notes: sub selects nine's complement of b with carry in

`timescale 1ns/1ps
`default_nettype none

interface dec_add_if;
   import bcd_pkg::*;
   logic [MAG_W-1:0] a;
   logic [MAG_W-1:0] b;
   logic sub;
   logic [MAG_W-1:0] sum;
   logic carry;
   modport unit (output a, output b, output sub, input sum, input carry);
   modport adder (input a, input b, input sub, output sum, output carry);
endinterface

`default_nettype wire
